// ---- hw/uctl_top.sv ----
// uctl_top: APB control/status registers, transmitter and receive flags
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module uctl_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uctl_pkg::uctl_rx_evt_t rx_evt,
  output logic serial_out_pin,
  output uctl_pkg::uctl_irq_t irq
);

  // byte address to register select, used by read and write paths
  function automatic uctl_pkg::uctl_sel_t reg_sel(input logic [7:0] addr);
    uctl_pkg::uctl_sel_t r;
    r = uctl_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[7:2])
        uctl_pkg::IDX_CTRL_ONE[5:0]: r = uctl_pkg::SEL_CTRL_ONE;
        uctl_pkg::IDX_CTRL_TWO[5:0]: r = uctl_pkg::SEL_CTRL_TWO;
        uctl_pkg::IDX_CTRL_THREE[5:0]: r = uctl_pkg::SEL_CTRL_THREE;
        uctl_pkg::IDX_STATUS_ONE[5:0]: r = uctl_pkg::SEL_STATUS_ONE;
        uctl_pkg::IDX_DATA_BUFFER[5:0]: r = uctl_pkg::SEL_DATA;
        default: r = uctl_pkg::SEL_NONE;
      endcase
    end
    return r;
  endfunction : reg_sel

  typedef struct packed {
    logic module_on;
    logic char9;
    logic wake_sel;
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic line_quiet_irq_en;
    logic tx_on;
    logic rx_on;
    logic rx_standby;
    logic send_brk;
    logic overrun_irq_en;
    logic noise_irq_en;
    logic framing_irq_en;
    logic parity_err_irq_en;
    logic tx_buf_empty;
    logic tx_done;
    logic [5:0] rx_flags;
    logic idle_ok;
    logic arm_tx;
    logic [5:0] arm_rx;
    logic pre_pend;
    logic brk_tail;
    logic brk_frame;
    uctl_pkg::uctl_tx_state_t tx_state;
    logic [3:0] bits_left;
    logic [7:0] baud;
    logic [10:0] shift;
    logic line;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    uctl_pkg::uctl_irq_t irq;
  } uctl_state_t;

  // data path storage, untouched by reset
  typedef struct packed {
    logic [7:0] data_buffer;
    logic tx_ninth_bit;
    logic [7:0] rx_data;
    logic rx_ninth_bit;
  } uctl_data_t;

  // rx_flags order: full, quiet, overrun, noise, framing, parity
  uctl_state_t s;
  uctl_state_t next_s;
  uctl_data_t d;
  uctl_data_t next_d;

  always_comb
  begin
    uctl_pkg::uctl_sel_t sel;
    logic setup;
    logic done_acc;
    logic wr;
    logic rd;
    logic [7:0] rv;
    logic [7:0] st;
    logic frame_end;
    logic tx_ok;
    logic [5:0] ev;
    logic wake_hit;
    logic msb;
    next_s = s;
    next_d = d;
    sel = reg_sel(paddr);
    setup = psel & ~penable;
    done_acc = psel & penable & s.pready;
    wr = done_acc & pwrite;
    rd = done_acc & ~pwrite;
    rv = 8'h00;
    frame_end = 1'b0;
    tx_ok = s.module_on & s.tx_on;
    ev = 6'h00;
    wake_hit = 1'b0;
    msb = 1'b0;
    // status image, fixed bit order
    st = {s.tx_buf_empty, s.tx_done, s.rx_flags}; // RULE19

    // zero-wait-state APB answer; read data captured in setup
    next_s.pready = setup;
    next_s.pslverr = setup & (sel == uctl_pkg::SEL_NONE);
    case (sel)
      uctl_pkg::SEL_CTRL_ONE:
      begin
        rv[uctl_pkg::MODULE_ON_POS] = s.module_on;
        rv[uctl_pkg::CHAR9_POS] = s.char9;
        rv[uctl_pkg::WAKE_SEL_POS] = s.wake_sel;
      end
      uctl_pkg::SEL_CTRL_TWO:
        rv = {s.tx_empty_irq_en, s.tx_done_irq_en, s.rx_full_irq_en, s.line_quiet_irq_en,
              s.tx_on, s.rx_on, s.rx_standby, s.send_brk};
      uctl_pkg::SEL_CTRL_THREE:
        rv = {d.rx_ninth_bit, d.tx_ninth_bit, 2'h0, s.overrun_irq_en, s.noise_irq_en,
              s.framing_irq_en, s.parity_err_irq_en};
      uctl_pkg::SEL_STATUS_ONE: rv = st;
      uctl_pkg::SEL_DATA: rv = d.rx_data;
      default: rv = 8'h00;
    endcase
    next_s.prdata = setup ? {24'h00_0000, rv} : s.prdata;

    // register writes at the completing access edge
    if (wr)
    begin
      case (sel)
        uctl_pkg::SEL_CTRL_ONE:
        begin
          next_s.module_on = pwdata[uctl_pkg::MODULE_ON_POS];
          next_s.char9 = pwdata[uctl_pkg::CHAR9_POS]; // RULE24
          next_s.wake_sel = pwdata[uctl_pkg::WAKE_SEL_POS];
        end
        uctl_pkg::SEL_CTRL_TWO:
        begin
          next_s.tx_empty_irq_en = pwdata[uctl_pkg::TX_EMPTY_IRQ_EN_POS];
          next_s.tx_done_irq_en = pwdata[uctl_pkg::TX_DONE_IRQ_EN_POS];
          next_s.rx_full_irq_en = pwdata[uctl_pkg::RX_FULL_IRQ_EN_POS];
          next_s.line_quiet_irq_en = pwdata[uctl_pkg::LINE_QUIET_IRQ_EN_POS];
          next_s.rx_standby = pwdata[uctl_pkg::RX_STANDBY_POS];
          next_s.send_brk = pwdata[uctl_pkg::SEND_BRK_POS];
          if (s.module_on) // RULE8
          begin
            next_s.tx_on = pwdata[uctl_pkg::TX_ON_POS];
            next_s.rx_on = pwdata[uctl_pkg::RX_ON_POS]; // RULE9
            // a rising enable queues a preamble, or an idle char mid-frame
            if (pwdata[uctl_pkg::TX_ON_POS] & ~s.tx_on)
            begin
              next_s.pre_pend = 1'b1; // RULE5 RULE7
            end
          end
        end
        uctl_pkg::SEL_CTRL_THREE:
        begin
          next_d.tx_ninth_bit = pwdata[uctl_pkg::TX_NINTH_BIT_POS];
          next_s.overrun_irq_en = pwdata[uctl_pkg::OVERRUN_IRQ_EN_POS]; // RULE16
          next_s.noise_irq_en = pwdata[uctl_pkg::NOISE_IRQ_EN_POS];
          next_s.framing_irq_en = pwdata[uctl_pkg::FRAMING_IRQ_EN_POS];
          next_s.parity_err_irq_en = pwdata[uctl_pkg::PARITY_ERR_IRQ_EN_POS];
        end
        uctl_pkg::SEL_DATA:
        begin
          next_d.data_buffer = pwdata[7:0];
          // second step of the empty-flag clear
          if (s.arm_tx)
          begin
            next_s.tx_buf_empty = 1'b0; // RULE18
            next_s.arm_tx = 1'b0;
          end
        end
        default: next_s.pslverr = 1'b0; // status and unmapped writes change nothing
      endcase
    end

    // status read arms clears for flags the reader actually saw set
    if (rd && sel == uctl_pkg::SEL_STATUS_ONE)
    begin
      next_s.arm_tx = s.prdata[uctl_pkg::TX_BUF_EMPTY_POS]; // RULE18
      next_s.arm_rx = s.prdata[5:0];
    end
    if (rd && sel == uctl_pkg::SEL_DATA)
    begin
      next_s.rx_flags = s.rx_flags & ~s.arm_rx;
      next_s.arm_rx = 6'h00;
      if (s.arm_rx[4])
      begin
        next_s.idle_ok = 1'b0;
      end
    end

    // receive events; disabled receiver leaves flags alone
    if (s.rx_on && s.module_on) // RULE9
    begin
      msb = s.char9 ? rx_evt.char_data[8] : rx_evt.char_data[7];
      // wake condition chosen by wake_sel
      wake_hit = s.wake_sel ? (rx_evt.char_valid & msb) : rx_evt.idle_seen; // RULE22
      if (s.rx_standby && wake_hit)
      begin
        next_s.rx_standby = 1'b0; // RULE10
      end
      if (!s.rx_standby || (s.wake_sel && wake_hit))
      begin
        if (rx_evt.char_valid)
        begin
          next_d.rx_data = rx_evt.char_data[7:0];
          next_d.rx_ninth_bit = msb; // RULE14
          next_s.idle_ok = 1'b1;
        end
        ev = {rx_evt.char_valid & ~s.rx_flags[5],
              rx_evt.idle_seen & s.idle_ok & ~s.rx_standby,
              rx_evt.char_valid & s.rx_flags[5] | rx_evt.overrun,
              rx_evt.noise, rx_evt.framing, rx_evt.parity};
        // overrun keeps the old character in the buffer
        if (s.rx_flags[5] && rx_evt.char_valid)
        begin
          next_d.rx_data = d.rx_data;
          next_d.rx_ninth_bit = d.rx_ninth_bit;
        end
      end
    end
    // a new event wins over a clear in the same cycle
    next_s.rx_flags = next_s.rx_flags | ev;

    // transmitter bit timing
    if (s.tx_state == uctl_pkg::TX_SEND)
    begin
      if (s.baud == uctl_pkg::BIT_CYCLES - 8'h01)
      begin
        next_s.baud = 8'h00;
        next_s.shift = {1'b1, s.shift[10:1]};
        next_s.bits_left = s.bits_left - 4'h1;
        frame_end = (s.bits_left == 4'h1);
      end
      else
      begin
        next_s.baud = s.baud + 8'h01;
      end
    end

    // pick the next frame: break, break tail, preamble, then data
    if (s.tx_state == uctl_pkg::TX_IDLE || frame_end)
    begin
      next_s.tx_state = uctl_pkg::TX_IDLE;
      next_s.baud = 8'h00;
      if (tx_ok && s.send_brk)
      begin
        // held break repeats with no one between frames
        next_s.tx_state = uctl_pkg::TX_SEND; // RULE12
        next_s.shift = 11'h000;
        next_s.bits_left = s.char9 ? uctl_pkg::FRAME_LEN9 : uctl_pkg::FRAME_LEN8;
        next_s.brk_frame = 1'b1;
      end
      else if (tx_ok && s.brk_frame)
      begin
        // single one after the last break
        next_s.tx_state = uctl_pkg::TX_SEND; // RULE11
        next_s.shift = 11'h7ff;
        next_s.bits_left = 4'h1;
        next_s.brk_frame = 1'b0;
      end
      else if (tx_ok && s.pre_pend)
      begin
        next_s.tx_state = uctl_pkg::TX_SEND; // RULE5
        next_s.shift = 11'h7ff;
        next_s.bits_left = s.char9 ? uctl_pkg::FRAME_LEN9 : uctl_pkg::FRAME_LEN8;
        next_s.pre_pend = 1'b0;
        next_s.brk_frame = 1'b0;
      end
      else if (tx_ok && !next_s.tx_buf_empty)
      begin
        next_s.tx_state = uctl_pkg::TX_SEND;
        next_s.brk_frame = 1'b0;
        if (s.char9)
        begin
          next_s.shift = {1'b1, d.tx_ninth_bit, d.data_buffer, 1'b0}; // RULE15
          next_s.bits_left = uctl_pkg::FRAME_LEN9;
        end
        else
        begin
          next_s.shift = {2'h3, d.data_buffer, 1'b0};
          next_s.bits_left = uctl_pkg::FRAME_LEN8;
        end
        next_s.tx_buf_empty = 1'b1; // RULE17
        next_s.arm_tx = 1'b0;
      end
      else
      begin
        // disabled or empty: line rests high
        next_s.shift = 11'h7ff; // RULE6
        next_s.brk_frame = 1'b0;
      end
    end

    // module off forces the transmitter empty and idle
    if (!s.module_on)
    begin
      next_s.tx_buf_empty = 1'b1; // RULE21
      next_s.tx_on = 1'b0;
      next_s.rx_on = 1'b0;
      next_s.pre_pend = 1'b0;
      next_s.tx_state = uctl_pkg::TX_IDLE;
      next_s.shift = 11'h7ff;
    end
    // complete when empty and nothing shifting or queued
    next_s.tx_done = next_s.tx_buf_empty & (next_s.tx_state == uctl_pkg::TX_IDLE)
                     & ~next_s.pre_pend & ~(tx_ok & s.send_brk) | ~s.module_on; // RULE23
    next_s.line = next_s.shift[0];

    // request lines, registered
    next_s.irq.tx = s.module_on & ((s.tx_buf_empty & s.tx_empty_irq_en) // RULE1 RULE21
                                   | (s.tx_done & s.tx_done_irq_en)); // RULE2
    next_s.irq.rx = ~s.rx_standby & ((s.rx_flags[5] & s.rx_full_irq_en) // RULE3 RULE10
                                     | (s.rx_flags[4] & s.line_quiet_irq_en)); // RULE4
    next_s.irq.err = (s.rx_flags[3] & s.overrun_irq_en) | (s.rx_flags[2] & s.noise_irq_en)
                     | (s.rx_flags[1] & s.framing_irq_en)
                     | (s.rx_flags[0] & s.parity_err_irq_en); // RULE16 RULE25
  end

  // control state; status flag reset values from the package, the rest zero or idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0; // RULE20
      s.tx_buf_empty <= uctl_pkg::STATUS_ONE_RESET[uctl_pkg::TX_BUF_EMPTY_POS]; // RULE19
      s.tx_done <= uctl_pkg::STATUS_ONE_RESET[uctl_pkg::TX_DONE_POS];
      s.shift <= 11'h7ff;
      s.line <= 1'b1;
      s.tx_state <= uctl_pkg::TX_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // data storage has no reset, so reset leaves ninth bits alone
  always_ff @(posedge pclk)
  begin
    d <= next_d; // RULE14 RULE15
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign serial_out_pin = s.line;
  assign irq = s.irq;

endmodule : uctl_top

// ---- hw/uctl_pkg.sv ----
// uctl_pkg: constants, register map and carrier types of the serial control block
// Function
// RULE1: empty flag irq gated by its enable
// RULE2: complete flag irq gated by its enable
// RULE3: receiver-full irq gated by its enable
// RULE4: idle-line irq gated by its enable
// RULE5: enabling transmitter sends 10/11-one preamble
// RULE6: disabling transmitter finishes frame, then line high
// RULE7: re-enable mid-frame queues one idle character
// RULE8: tx/rx enable writes ignored while module off
// RULE9: rx enable gates receiver, flags kept
// RULE10: standby suppresses rx irq; wake clears it
// RULE11: break toggle sends one break then a one
// RULE12: break held sends breaks back to back
// RULE13: software must not toggle break too early
// RULE14: received ninth bit: bit8 or bit7 copy
// RULE15: transmit ninth bit loaded with data
// RULE16: error enables gate their error flags
// RULE17: empty flag set when data moves to shifter
// RULE18: empty flag cleared by status read, data write
// RULE19: status layout fixed, read only, reset c0
// RULE20: reset clears second control register bits
// RULE21: module off sets tx flags, masks tx irq
// RULE22: wake select: 1 address mark, 0 idle
// RULE23: complete flag when empty and shifter idle
// RULE24: length bit selects nine or eight bits
// RULE25: three request lines: tx, rx, error
package uctl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'h38;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h39;
  localparam logic [7:0] IDX_CTRL_THREE = 8'h3a;
  localparam logic [7:0] IDX_STATUS_ONE = 8'h3b;
  localparam logic [7:0] IDX_DATA_BUFFER = 8'h3d;
  // control one fields
  localparam int MODULE_ON_POS = 6;
  localparam int CHAR9_POS = 4;
  localparam int WAKE_SEL_POS = 3;
  // control two fields
  localparam int TX_EMPTY_IRQ_EN_POS = 7;
  localparam int TX_DONE_IRQ_EN_POS = 6;
  localparam int RX_FULL_IRQ_EN_POS = 5;
  localparam int LINE_QUIET_IRQ_EN_POS = 4;
  localparam int TX_ON_POS = 3;
  localparam int RX_ON_POS = 2;
  localparam int RX_STANDBY_POS = 1;
  localparam int SEND_BRK_POS = 0;
  // control three fields
  localparam int RX_NINTH_BIT_POS = 7;
  localparam int TX_NINTH_BIT_POS = 6;
  localparam int OVERRUN_IRQ_EN_POS = 3;
  localparam int NOISE_IRQ_EN_POS = 2;
  localparam int FRAMING_IRQ_EN_POS = 1;
  localparam int PARITY_ERR_IRQ_EN_POS = 0;
  // status one fields
  localparam int TX_BUF_EMPTY_POS = 7;
  localparam int TX_DONE_POS = 6;
  localparam int RX_BUF_FULL_POS = 5;
  localparam int LINE_QUIET_POS = 4;
  localparam int OVERRUN_POS = 3;
  localparam int NOISE_FLAG_POS = 2;
  localparam int FRAMING_FLAG_POS = 1;
  localparam int PARITY_FLAG_POS = 0;
  localparam logic [7:0] STATUS_ONE_RESET = 8'hc0;
  // frame lengths in bits and bit time in pclk cycles
  localparam logic [3:0] FRAME_LEN8 = 4'ha;
  localparam logic [3:0] FRAME_LEN9 = 4'hb;
  localparam logic [7:0] BIT_CYCLES = 8'h10;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_CTRL_ONE, SEL_CTRL_TWO, SEL_CTRL_THREE, SEL_STATUS_ONE, SEL_DATA
  } uctl_sel_t;

  typedef enum logic {TX_IDLE, TX_SEND} uctl_tx_state_t;

  // events from the receive sampler
  typedef struct packed {
    logic char_valid;
    logic [8:0] char_data;
    logic idle_seen;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } uctl_rx_evt_t;

  // request lines
  typedef struct packed {
    logic tx;
    logic rx;
    logic err;
  } uctl_irq_t;
endpackage : uctl_pkg

// ---- dv/uctl_chk.sv ----
// uctl_chk: port-level assertions for the serial control block
`timescale 1ns/1ns
module uctl_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out_pin,
  input wire uctl_pkg::uctl_irq_t irq
);
  // shadow enables and line run length; only writes that land count
  typedef struct packed {
    logic on;
    logic [3:0] c2;
    logic [3:0] c3;
    logic p;
    logic [7:0] run;
  } uctl_shadow_t;
  uctl_shadow_t s;
  uctl_shadow_t next_s;
  logic wr;
  assign wr = psel & penable & pready & pwrite & ~pslverr;
  always_comb
  begin
    next_s = s;
    next_s.p = serial_out_pin;
    next_s.run = (serial_out_pin != s.p) ? 8'h01 : s.run + 8'h01; // wraps, mod 16 is kept
    if (wr && paddr == 8'he0)
      next_s.on = pwdata[6];
    if (wr && paddr == 8'he4)
      next_s.c2 = pwdata[7:4];
    if (wr && paddr == 8'he8)
      next_s.c3 = pwdata[3:0];
  end
  // registered shadow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '{p: 1'b1, default: '0};
    else
      s <= next_s;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == '0)
    else $error("unmapped read not zero");
  tx_irq_mask_a: assert property (!(s.on && |s.c2[3:2]) && $past(!(s.on && |s.c2[3:2]))
    |-> !irq.tx) else $error("tx request while masked");
  rx_irq_mask_a: assert property (s.c2[1:0] == 2'b00 && $past(s.c2[1:0]) == 2'b00
    |-> !irq.rx) else $error("rx request while masked");
  err_irq_mask_a: assert property (s.c3 == 4'h0 && $past(s.c3) == 4'h0 |-> !irq.err)
    else $error("error request while masked");
  idle_high_a: assert property (!s.on [*3] |-> serial_out_pin)
    else $error("line low while module off");
  bit_time_a: assert property ($past(s.on) && s.on && !s.p && serial_out_pin
    |-> s.run[3:0] == 4'h0) else $error("low run not whole bits");
endmodule : uctl_chk

bind uctl_top uctl_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .serial_out_pin, .irq);

// ---- dv/uctl_remote.sv ----
// uctl_remote: far-end transceiver; decodes the line, feeds receive events
`timescale 1ns/1ns
module uctl_remote
(
  input wire logic pclk,
  input wire logic line,
  input wire logic nine,
  output uctl_pkg::uctl_rx_evt_t rx_evt
);
  logic [9:0] frame;
  int hi_run;
  int last_hi;
  int nframes;
  // one-cycle event toward the block
  task automatic pulse(input logic [14:0] v);
    @(posedge pclk);
    rx_evt <= v;
    @(posedge pclk);
    rx_evt <= '0;
  endtask : pulse
  // mid-bit sampling; a zero stop bit still ends on a bit boundary
  initial
  begin
    rx_evt = '0;
    hi_run = 0;
    nframes = 0;
    forever
    begin
      @(posedge pclk);
      if (line !== 1'b0)
        hi_run++;
      else
      begin
        last_hi = hi_run;
        frame = '1;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < (nine ? 10 : 9); i++)
        begin
          repeat (16) @(posedge pclk);
          frame[i] = line;
        end
        repeat (8) @(posedge pclk);
        hi_run = 0;
        nframes++;
      end
    end
  end
endmodule : uctl_remote

// ---- dv/uctl_top_test.sv ----
// uctl_top_test: bus-level regression of the serial control block
`timescale 1ns/1ns
module uctl_top_test;
  localparam logic [7:0] C1 = uctl_pkg::IDX_CTRL_ONE << 2;
  localparam logic [7:0] C2 = uctl_pkg::IDX_CTRL_TWO << 2;
  localparam logic [7:0] C3 = uctl_pkg::IDX_CTRL_THREE << 2;
  localparam logic [7:0] ST = uctl_pkg::IDX_STATUS_ONE << 2;
  localparam logic [7:0] DB = uctl_pkg::IDX_DATA_BUFFER << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serial_out_pin;
  logic nine = 1'b0;
  uctl_pkg::uctl_rx_evt_t rx_evt;
  uctl_pkg::uctl_irq_t irq;
  logic [7:0] rd;
  logic err;
  int miscompares = 0;
  int tests_run = 0;
  uctl_remote remote (.pclk, .line(serial_out_pin), .nine, .rx_evt);
  uctl_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_evt, .serial_out_pin, .irq);
  // free-running clock
  always #10 pclk = ~pclk;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // one transfer; held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog may end a wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    cmp(rd & m, e);
  endtask : rdc
  // request lines lag the enables by one cycle
  task automatic irqc(input logic [2:0] e);
    repeat (2) @(posedge pclk);
    cmp({5'h00, irq}, {5'h00, e});
  endtask : irqc
  task automatic wait_frames(input int f);
    for (int n = 0; n < 1000 && remote.nframes < f; n++)
      @(posedge pclk);
    // a frame that never arrives counts against the run
    if (remote.nframes < f)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, remote.nframes, f);
    end
  endtask : wait_frames
  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ST, 8'hff, 8'hc0);
    rdc(C2, 8'hff, 8'h00);
    rdc(C3, 8'h0f, 8'h00);
    rdc(8'hf0, 8'hff, 8'h00);
    cmp({7'h00, err}, 8'h01);
    xfer(1'b1, 8'hf0, 8'hff);
    cmp({7'h00, err}, 8'h01);
    xfer(1'b1, ST, 8'h00);
    rdc(ST, 8'hff, 8'hc0);
    xfer(1'b1, C2, 8'hcc);
    rdc(C2, 8'hff, 8'hc0);
    irqc(3'b000);
    xfer(1'b1, C1, 8'h40);
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, C2, 8'h80 >> k);
      irqc(3'b100);
      xfer(1'b1, C2, 8'h00);
      irqc(3'b000);
    end
    xfer(1'b1, C2, 8'h80);
    xfer(1'b1, C1, 8'h00);
    irqc(3'b000);
    // receive in both lengths, ninth bit and flag retention
    for (int m = 0; m < 2; m++)
    begin
      xfer(1'b1, C1, {3'b010, m[0], 4'h0});
      xfer(1'b1, C2, 8'h24);
      remote.pulse({1'b1, 9'h17f, 5'h00});
      irqc(3'b010);
      rdc(C3, 8'h80, {m[0], 7'h00});
      xfer(1'b1, C2, 8'h20);
      irqc(3'b010);
      rdc(ST, 8'h20, 8'h20);
      rdc(DB, 8'hff, 8'h7f);
      irqc(3'b000);
    end
    xfer(1'b1, C2, 8'h14);
    remote.pulse({1'b1, 9'h055, 5'h00});
    remote.pulse(15'h0010);
    irqc(3'b010);
    rdc(ST, 8'h30, 8'h30);
    rdc(DB, 8'h00, 8'h00);
    // standby: characters ignored, idle line wakes the receiver
    xfer(1'b1, C2, 8'h26);
    remote.pulse({1'b1, 9'h0aa, 5'h00});
    irqc(3'b000);
    rdc(C2, 8'h02, 8'h02);
    remote.pulse(15'h0010);
    rdc(C2, 8'h02, 8'h00);
    rdc(ST, 8'h30, 8'h00);
    irqc(3'b000);
    for (int k = 0; k < 4; k++)
    begin
      remote.pulse(15'h0001 << k);
      irqc(3'b000);
      xfer(1'b1, C3, 8'h01 << k);
      irqc(3'b001);
      rdc(ST, 8'h0f, 8'h01 << k);
      rdc(DB, 8'h00, 8'h00);
      irqc(3'b000);
      xfer(1'b1, C3, 8'h00);
    end
    // transmit: preamble length, frame, empty and complete flags
    for (int m = 0; m < 2; m++)
    begin
      nine <= m[0];
      xfer(1'b1, C1, {3'b010, m[0], 4'h0});
      rdc(ST, 8'h80, 8'h80);
      xfer(1'b1, C2, 8'h08);
      remote.hi_run = 0;
      remote.nframes = 0;
      xfer(1'b1, DB, 8'ha5);
      rdc(ST, 8'hc0, 8'h00);
      wait_frames(1);
      cmp(remote.frame[7:0], 8'ha5);
      cmp({6'h00, remote.frame[9:8]}, m ? 8'h02 : 8'h03);
      cmp({7'h00, (remote.last_hi - 16 * m) inside {[158:166]}}, 8'h01);
      rdc(ST, 8'hc0, 8'hc0);
      xfer(1'b1, C2, 8'h00);
    end
    xfer(1'b1, C2, 8'h08);
    repeat (200) @(posedge pclk);
    remote.nframes = 0;
    xfer(1'b1, C2, 8'h09);
    wait_frames(2);
    cmp(remote.frame[7:0], 8'h00);
    cmp({6'h00, remote.frame[9:8]}, 8'h00);
    xfer(1'b1, C2, 8'h08);
    repeat (400) @(posedge pclk);
    cmp({7'h00, serial_out_pin}, 8'h01);
    tally_and_finish();
  end
  // watchdog, well past the expected run length
  initial
  begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
endmodule : uctl_top_test
